// ==== hw/prox_pair_config.sv ====
// Proximity pair configuration: offset and photodiode selection registers with pair signal path
// Overview of operation
// R1 - South and west diodes are summed into one pair whose signal feeds proximity.
// R2 - North and east diodes form a second, separate pair.
// R3 - The 8-bit south/west offset setting sets a crosstalk correction on that pair.
// R4 - The offset is sign/magnitude: top bit sign, seven magnitude bits, range +127 to -127.
// R5 - Software selects through the selection register which diodes take part in proximity.
// R6 - Software writes zero to the two reserved top bits of the selection register.
// R7 - With one diode of a pair contributing and no compensation, the result stops at 127.
// R8 - Gain compensation in bit 5 doubles a half-pair signal so the result can reach 255.
// R9 - Software should turn on compensation whenever masking leaves a single diode in a pair.
// R10 - Mask bits north 3, south 2, west 1, east 0 each drop their diode when set.
// R11 - Sleep-after-interrupt in bit 4 enters low power while the interrupt line is up, resuming once cleared.
module prox_pair_config (
   // Clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst_n,
   // Serial register port
   input  wire logic [7:0]              reg_addr,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output logic      [7:0]              reg_rdata,
   // Front end and neighbour registers
   input  wire prox_cfg_pkg::diode_set_s diodes,
   input  wire logic [7:0]              ne_pair_offset,
   input  wire logic                    irq_pin,
   // Results
   output prox_cfg_pkg::pair_out_s      pair_signal,
   output logic                         low_power
);

   typedef struct packed {
      logic [7:0]              sw_offset;
      prox_cfg_pkg::sel_cfg_s  sel;
      logic [7:0]              rdata;
      prox_cfg_pkg::pair_out_s pairs;
      prox_cfg_pkg::power_e    power;
   } core_state_s;

   core_state_s st;
   core_state_s next_st;

   logic [prox_cfg_pkg::DIODE_W-1:0] pair_a    [prox_cfg_pkg::PAIR_COUNT];
   logic [prox_cfg_pkg::DIODE_W-1:0] pair_b    [prox_cfg_pkg::PAIR_COUNT];
   logic                             pair_ma   [prox_cfg_pkg::PAIR_COUNT];
   logic                             pair_mb   [prox_cfg_pkg::PAIR_COUNT];
   logic [7:0]                       pair_ofs  [prox_cfg_pkg::PAIR_COUNT];
   logic [7:0]                       pair_res  [prox_cfg_pkg::PAIR_COUNT];
   logic                             pair_one  [prox_cfg_pkg::PAIR_COUNT];

   // Pair wiring: north with east, south with west
   always_comb begin
      pair_a[prox_cfg_pkg::PAIR_NE]   = diodes.north; // R2
      pair_b[prox_cfg_pkg::PAIR_NE]   = diodes.east; // R2
      pair_ma[prox_cfg_pkg::PAIR_NE]  = st.sel.mask_north_diode; // R10
      pair_mb[prox_cfg_pkg::PAIR_NE]  = st.sel.mask_east_diode; // R10
      pair_ofs[prox_cfg_pkg::PAIR_NE] = ne_pair_offset;
      pair_a[prox_cfg_pkg::PAIR_SW]   = diodes.south; // R1
      pair_b[prox_cfg_pkg::PAIR_SW]   = diodes.west; // R1
      pair_ma[prox_cfg_pkg::PAIR_SW]  = st.sel.mask_south_diode; // R10
      pair_mb[prox_cfg_pkg::PAIR_SW]  = st.sel.mask_west_diode; // R10
      pair_ofs[prox_cfg_pkg::PAIR_SW] = st.sw_offset; // R3
   end

   for (genvar p = 0; p < prox_cfg_pkg::PAIR_COUNT; p++) begin : g_pair
      diode_pair_calc u_calc (
         .diode_a      (pair_a[p]),
         .diode_b      (pair_b[p]),
         .mask_a       (pair_ma[p]),
         .mask_b       (pair_mb[p]),
         .offset       (pair_ofs[p]),
         .gain_comp    (st.sel.pair_gain_comp_en),
         .result       (pair_res[p]),
         .single_diode (pair_one[p])
      );
   end

   always_comb begin
      next_st = st;
      // Register writes; reserved bits are dropped so they always read zero
      if (reg_wr && reg_addr == prox_cfg_pkg::SW_OFFSET_ADDR) begin
         next_st.sw_offset = reg_wdata; // R3 R4
      end
      if (reg_wr && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR) begin
         next_st.sel      = prox_cfg_pkg::sel_cfg_s'(reg_wdata); // R5
         next_st.sel.rsvd = prox_cfg_pkg::RSVD_ZERO; // R6
      end
      // Reads return the value held before a same-cycle write
      if (reg_rd) begin
         unique case (reg_addr)
            prox_cfg_pkg::SW_OFFSET_ADDR:  next_st.rdata = st.sw_offset;
            prox_cfg_pkg::SEL_CONFIG_ADDR: next_st.rdata = st.sel;
            default:                       next_st.rdata = prox_cfg_pkg::READ_UNMAPPED;
         endcase
      end
      next_st.pairs.ne = pair_res[prox_cfg_pkg::PAIR_NE]; // R2
      next_st.pairs.sw = pair_res[prox_cfg_pkg::PAIR_SW]; // R1
      // Sleep holds only while the line is up, so a host clear always wakes us
      unique case (st.power)
         prox_cfg_pkg::PWR_ACTIVE: begin
            if (st.sel.sleep_after_irq_en && irq_pin) begin
               next_st.power = prox_cfg_pkg::PWR_SLEEP; // R11
            end
         end
         prox_cfg_pkg::PWR_SLEEP: begin
            if (!irq_pin) begin
               next_st.power = prox_cfg_pkg::PWR_ACTIVE; // R11
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st.sw_offset <= prox_cfg_pkg::SW_OFFSET_RESET;
         st.sel       <= prox_cfg_pkg::sel_cfg_s'(prox_cfg_pkg::SEL_RESET);
         st.rdata     <= prox_cfg_pkg::READ_UNMAPPED;
         st.pairs     <= '0;
         st.power     <= prox_cfg_pkg::PWR_ACTIVE;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata   = st.rdata;
   assign pair_signal = st.pairs;
   assign low_power   = (st.power == prox_cfg_pkg::PWR_SLEEP);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_sw_offset_store: assert property ( // R3
      reg_wr && reg_addr == prox_cfg_pkg::SW_OFFSET_ADDR |=> st.sw_offset == $past(reg_wdata))
      else $error("offset write not stored");

   a_rsvd_read_zero: assert property ( // R6
      reg_rd && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR |=> reg_rdata[7:6] == 2'h0)
      else $error("reserved selection bits not zero");

   a_sel_write_read: assert property ( // R5
      reg_wr && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR && !reg_rd
      ##1 reg_rd && !reg_wr && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR
      |=> reg_rdata == {2'h0, $past(reg_wdata[5:0], 2)})
      else $error("selection readback wrong");

   a_half_pair_limit: assert property ( // R7
      st.sel.mask_south_diode != st.sel.mask_west_diode && !st.sel.pair_gain_comp_en
      |=> pair_signal.sw <= 8'h7f)
      else $error("half pair exceeded 127");

   a_neg_offset_mag: assert property ( // R4
      st.sel.mask_south_diode && st.sel.mask_west_diode && st.sw_offset[7]
      |=> pair_signal.sw == {1'b0, $past(st.sw_offset[6:0])})
      else $error("sign magnitude offset wrong");

   a_gain_doubles: assert property ( // R8
      st.sel.pair_gain_comp_en && st.sel.mask_west_diode && !st.sel.mask_south_diode
      && st.sw_offset == 8'h00 && diodes.south == 7'h7f
      |=> pair_signal.sw == 8'hfe)
      else $error("gain compensation not doubling");

   a_mask_all_zero: assert property ( // R10
      st.sel[3:0] == 4'hf && st.sw_offset[7] == 1'b0 && ne_pair_offset[7] == 1'b0
      |=> pair_signal == '0)
      else $error("masked diodes still contribute");

   a_sleep_enter: assert property ( // R11
      st.sel.sleep_after_irq_en && irq_pin && !low_power |=> low_power)
      else $error("no sleep after interrupt");

   a_sleep_exit: assert property ( // R11
      low_power && !irq_pin |=> !low_power ##1 (!low_power || $past(irq_pin)))
      else $error("no wake after interrupt clear");

   a_sel_write_store: assert property ( // R5
      reg_wr && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR |=> st.sel[5:0] == $past(reg_wdata[5:0]))
      else $error("selection write not stored");

   a_sel_keeps_value: assert property ( // R5
      !(reg_wr && reg_addr == prox_cfg_pkg::SEL_CONFIG_ADDR) |=> $stable(st.sel))
      else $error("selection changed without a write");

   a_ofs_keeps_value: assert property ( // R3
      !(reg_wr && reg_addr == prox_cfg_pkg::SW_OFFSET_ADDR) |=> $stable(st.sw_offset))
      else $error("offset changed without a write");

   a_ofs_read_back: assert property ( // R4
      reg_rd && reg_addr == prox_cfg_pkg::SW_OFFSET_ADDR |=> reg_rdata == $past(st.sw_offset))
      else $error("offset readback wrong");

   a_unmapped_read_zero: assert property ( // R5
      reg_rd && reg_addr != prox_cfg_pkg::SW_OFFSET_ADDR && reg_addr != prox_cfg_pkg::SEL_CONFIG_ADDR
      |=> reg_rdata == prox_cfg_pkg::READ_UNMAPPED)
      else $error("unmapped read not zero");

   a_rdata_hold: assert property ( // R5
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without a read");

   a_sw_full_pair: assert property ( // R1
      !st.sel.mask_south_diode && !st.sel.mask_west_diode && st.sw_offset == 8'h00
      |=> pair_signal.sw == 8'($past(diodes.south)) + 8'($past(diodes.west)))
      else $error("south west pair sum wrong");

   a_ne_full_pair: assert property ( // R2
      !st.sel.mask_north_diode && !st.sel.mask_east_diode && ne_pair_offset == 8'h00
      |=> pair_signal.ne == 8'($past(diodes.north)) + 8'($past(diodes.east)))
      else $error("north east pair sum wrong");

   a_ne_half_limit: assert property ( // R7
      st.sel.mask_north_diode != st.sel.mask_east_diode && !st.sel.pair_gain_comp_en
      |=> pair_signal.ne <= 8'h7f)
      else $error("north east half pair exceeded 127");

   a_sw_both_masked: assert property ( // R10
      st.sel.mask_south_diode && st.sel.mask_west_diode && !st.sw_offset[7]
      |=> pair_signal.sw == 8'h00)
      else $error("masked south west pair not zero");

   a_sleep_needs_enable: assert property ( // R11
      !st.sel.sleep_after_irq_en && !low_power |=> !low_power)
      else $error("sleep without enable");

   a_sleep_holds: assert property ( // R11
      low_power && irq_pin |=> low_power)
      else $error("woke while interrupt still up");

   c_sleep_cycle: cover property (!low_power ##1 low_power [*2] ##1 !low_power);
   c_gain_full:   cover property (st.sel.pair_gain_comp_en ##1 pair_signal.sw == 8'hff);
   c_neg_offset:  cover property (st.sw_offset[7] && !st.sel.mask_south_diode ##1 pair_signal.sw != 8'h00);
   c_all_masked:  cover property (st.sel[3:0] == 4'hf ##1 pair_signal == '0);
   c_unmapped_rd: cover property (reg_rd && reg_addr != prox_cfg_pkg::SW_OFFSET_ADDR
      && reg_addr != prox_cfg_pkg::SEL_CONFIG_ADDR ##1 reg_rdata == prox_cfg_pkg::READ_UNMAPPED);

endmodule // prox_pair_config

// ==== inc/prox_cfg_pkg.sv ====
// Package for the proximity diode pair offset and selection configuration
package prox_cfg_pkg;

   // Register addresses on the serial register port
   localparam logic [7:0] SW_OFFSET_ADDR  = 8'h9e;
   localparam logic [7:0] SEL_CONFIG_ADDR = 8'h9f;

   // Reset values (none documented; zero keeps all diodes in, no offset)
   localparam logic [7:0] SW_OFFSET_RESET = 8'h00;
   localparam logic [7:0] SEL_RESET       = 8'h00;
   localparam logic [7:0] READ_UNMAPPED   = 8'h00;

   // Offset field: sign bit on top, seven magnitude bits below
   localparam int         OFS_SIGN_BIT = 7;
   localparam int         OFS_MAG_W    = 7;

   // Each diode delivers half of a pair's full-scale signal
   localparam int         DIODE_W       = 7;
   localparam int         CALC_W        = 11;
   localparam logic [7:0] HALF_LIMIT    = 8'h7f;
   localparam logic [7:0] FULL_LIMIT    = 8'hff;
   localparam int         PAIR_COUNT    = 2;
   localparam int         PAIR_NE       = 0;
   localparam int         PAIR_SW       = 1;

   // Photodiode selection register layout, bit 7 down to bit 0
   typedef struct packed {
      logic [1:0] rsvd;
      logic       pair_gain_comp_en;
      logic       sleep_after_irq_en;
      logic       mask_north_diode;
      logic       mask_south_diode;
      logic       mask_west_diode;
      logic       mask_east_diode;
   } sel_cfg_s;

   localparam logic [1:0] RSVD_ZERO = 2'h0;

   // Raw diode levels from the front end
   typedef struct packed {
      logic [DIODE_W-1:0] north;
      logic [DIODE_W-1:0] south;
      logic [DIODE_W-1:0] west;
      logic [DIODE_W-1:0] east;
   } diode_set_s;

   // Per-pair corrected signals toward the proximity converter
   typedef struct packed {
      logic [7:0] ne;
      logic [7:0] sw;
   } pair_out_s;

   typedef enum logic {
      PWR_ACTIVE,
      PWR_SLEEP
   } power_e;

endpackage

// ==== hw/diode_pair_calc.sv ====
// Combinational signal path of one photodiode pair: masking, offset, gain, limit
module diode_pair_calc (
   // Diodes of the pair
   input  wire logic [prox_cfg_pkg::DIODE_W-1:0] diode_a,
   input  wire logic [prox_cfg_pkg::DIODE_W-1:0] diode_b,
   input  wire logic                             mask_a,
   input  wire logic                             mask_b,
   // Settings
   input  wire logic [7:0]                       offset,
   input  wire logic                             gain_comp,
   // Result
   output logic      [7:0]                       result,
   output logic                                  single_diode
);

   localparam int CW = prox_cfg_pkg::CALC_W;

   logic        [CW-1:0] sum;
   logic        [CW-1:0] mag;
   logic signed [CW-1:0] corr;
   logic signed [CW-1:0] scaled;
   logic        [7:0]    limit;

   always_comb begin
      sum = CW'(mask_a ? '0 : diode_a) + CW'(mask_b ? '0 : diode_b);
      mag = CW'(offset[prox_cfg_pkg::OFS_MAG_W-1:0]);
      // Negative offset adds back, positive one removes crosstalk
      corr = offset[prox_cfg_pkg::OFS_SIGN_BIT] ? $signed(sum + mag) : $signed(sum - mag); // R3 R4
      single_diode = mask_a ^ mask_b;
      scaled = (gain_comp && single_diode) ? (corr <<< 1) : corr; // R8
      // Without compensation a half pair can only reach half scale
      limit = (single_diode && !gain_comp) ? prox_cfg_pkg::HALF_LIMIT : prox_cfg_pkg::FULL_LIMIT; // R7
      if (scaled < 0) begin
         result = '0;
      end else if (scaled > $signed(CW'(limit))) begin
         result = limit;
      end else begin
         result = scaled[7:0];
      end
   end

endmodule // diode_pair_calc

// ==== bench/test_prox_diode_pair_offset_config.sv ====
// Self-checking bench for the proximity pair offset and photodiode selection block
module test_prox_diode_pair_offset_config;
   timeunit 1ns;
   timeprecision 100ps;

   logic                     core_clk = 1'b0;
   logic                     rst_n = 1'b0;
   logic [7:0]               reg_addr = 8'h00;
   logic [7:0]               reg_wdata = 8'h00;
   logic                     reg_wr = 1'b0;
   logic                     reg_rd = 1'b0;
   logic [7:0]               reg_rdata;
   prox_cfg_pkg::diode_set_s diodes = '0;
   logic [7:0]               ne_pair_offset = 8'h00;
   logic                     irq_pin = 1'b0;
   prox_cfg_pkg::pair_out_s  pair_signal;
   logic                     low_power;
   int                       miscompares = 0;
   int                       checks_done = 0;
   logic [7:0]               m_ofs;
   logic [7:0]               m_sel;
   logic [7:0]               dir_ofs [$] = {8'h00, 8'h00, 8'h81, 8'h05};
   logic [7:0]               dir_sel [$] = {8'h00, 8'h22, 8'h22, 8'h0f};

   prox_pair_config prox_pair_config_inst (
      .core_clk       (core_clk),
      .rst_n          (rst_n),
      .reg_addr       (reg_addr),
      .reg_wdata      (reg_wdata),
      .reg_wr         (reg_wr),
      .reg_rd         (reg_rd),
      .reg_rdata      (reg_rdata),
      .diodes         (diodes),
      .ne_pair_offset (ne_pair_offset),
      .irq_pin        (irq_pin),
      .pair_signal    (pair_signal),
      .low_power      (low_power)
   );

   always #2 core_clk = ~core_clk;

   // Reference pair path: offset first, then compensation, then limits
   function automatic logic [7:0] pair_model(int a, int b, bit ma, bit mb, logic [7:0] ofs, bit gc);
      int v;
      int lim;
      v = (ma ? 0 : a) + (mb ? 0 : b);
      v = ofs[7] ? v + int'(ofs[6:0]) : v - int'(ofs[6:0]);
      lim = 255;
      if (ma ^ mb) begin
         if (gc) v = v * 2;
         else lim = 127;
      end
      if (v < 0) v = 0;
      if (v > lim) v = lim;
      return v[7:0];
   endfunction

   task automatic finish_test;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Strobes stay up between back-to-back transfers, so no strobe is set twice in one step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_rd = 1'b0;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      tick;
      if (a == prox_cfg_pkg::SW_OFFSET_ADDR) m_ofs = d;
      if (a == prox_cfg_pkg::SEL_CONFIG_ADDR) m_sel = {2'h0, d[5:0]};
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      reg_wr = 1'b0;
      reg_addr = a;
      reg_rd = 1'b1;
      tick;
      chk("reg_rdata", exp, reg_rdata);
   endtask

   task automatic idle;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tick;
   endtask

   // Run is a few hundred cycles; the limit leaves ample margin
   initial begin
      #40000;
      miscompares++;
      finish_test;
   end

   initial begin
      void'($urandom(32'h83bc9c32));
      m_ofs = prox_cfg_pkg::SW_OFFSET_RESET;
      m_sel = prox_cfg_pkg::SEL_RESET;
      repeat (6) @(posedge core_clk);
      #1 rst_n = 1'b1;
      rd_chk(prox_cfg_pkg::SW_OFFSET_ADDR, prox_cfg_pkg::SW_OFFSET_RESET);
      chk("low_power", 8'h00, {7'h0, low_power});
      rd_chk(prox_cfg_pkg::SEL_CONFIG_ADDR, prox_cfg_pkg::SEL_RESET);
      // Unmapped neighbour address must neither store nor disturb the offset
      wr(8'h9d, 8'h5a);
      rd_chk(8'h9d, prox_cfg_pkg::READ_UNMAPPED);
      rd_chk(prox_cfg_pkg::SW_OFFSET_ADDR, m_ofs);
      // Every mask, sleep and compensation setting, with random levels and offsets
      for (int i = 0; i < 64; i++) begin
         wr(prox_cfg_pkg::SW_OFFSET_ADDR, (i % 8 == 0) ? 8'h81 + 8'(i / 8 * 18) : 8'($urandom));
         wr(prox_cfg_pkg::SEL_CONFIG_ADDR, 8'(i));
         rd_chk(prox_cfg_pkg::SEL_CONFIG_ADDR, m_sel);
         rd_chk(prox_cfg_pkg::SW_OFFSET_ADDR, m_ofs);
         diodes = (i % 4 == 0) ? '1 : prox_cfg_pkg::diode_set_s'(28'($urandom));
         ne_pair_offset = 8'($urandom);
         idle;
         chk("pair_signal.sw", pair_model(diodes.south, diodes.west, m_sel[2], m_sel[1], m_ofs, m_sel[5]),
             pair_signal.sw);
         chk("pair_signal.ne", pair_model(diodes.north, diodes.east, m_sel[3], m_sel[0], ne_pair_offset,
             m_sel[5]), pair_signal.ne);
      end
      // Zero offset plain sum, doubled half pair, clamp at full scale, every diode masked
      diodes = '1;
      ne_pair_offset = 8'h00;
      foreach (dir_ofs[k]) begin
         wr(prox_cfg_pkg::SW_OFFSET_ADDR, dir_ofs[k]);
         wr(prox_cfg_pkg::SEL_CONFIG_ADDR, dir_sel[k]);
         idle;
         chk("pair_signal.sw", pair_model(diodes.south, diodes.west, m_sel[2], m_sel[1], m_ofs, m_sel[5]),
             pair_signal.sw);
         chk("pair_signal.ne", pair_model(diodes.north, diodes.east, m_sel[3], m_sel[0], ne_pair_offset,
             m_sel[5]), pair_signal.ne);
      end
      // Sleep is entered on the interrupt line only while enabled, and ends when the line drops even with the enable cleared
      wr(prox_cfg_pkg::SEL_CONFIG_ADDR, 8'h10);
      irq_pin = 1'b1;
      idle;
      chk("low_power", 8'h01, {7'h0, low_power});
      idle;
      chk("low_power", 8'h01, {7'h0, low_power});
      irq_pin = 1'b0;
      idle;
      chk("low_power", 8'h00, {7'h0, low_power});
      irq_pin = 1'b1;
      idle;
      // Dropping the enable while asleep must not wake the block
      wr(prox_cfg_pkg::SEL_CONFIG_ADDR, 8'h00);
      chk("low_power", 8'h01, {7'h0, low_power});
      irq_pin = 1'b0;
      idle;
      chk("low_power", 8'h00, {7'h0, low_power});
      irq_pin = 1'b1;
      idle;
      idle;
      chk("low_power", 8'h00, {7'h0, low_power});
      irq_pin = 1'b0;
      idle;
      finish_test;
   end
endmodule // test_prox_diode_pair_offset_config
